// ### rtl/dsl_spi_load.v
// Serial command front end and code register update of the converter
//
// Behaviour
// - Frame opens on select low; sample rising
// - Serial output changes on clock falling edge
// - Under 24 rising edges aborts, nothing done
// - Extra bits flow; decode last 24
// - 24-bit shift FIFO, MSB first, shifts out
// - Output released while select high
// - Select fall shows MSB; first change later
// - Word is command byte then data
// - Read commands copy chosen register to FIFO
// - Reads take two frames; echo command
// - No bit count for decode; decode on select rise
// - Data passes through after 24 cycles
// - Writes land in preload; output from code
// - Midscale pin picks power-up zero/midscale
// - Write-block mode holds data in preload
// - Load command and load pin transfer
// - Update and all writes load both
// - Write-through loads both on select rise
// - Power-down chooses high impedance or pulldown
// - After decode, act on command and pin
// - Load pin low copies preload continuously
// - Clear pin or command forces reset code
// - Plain write follows write mode bit
// - Load command uses channel bit mask

// Timing limits for the user
// Every pin passes three flip-flops and an agreement filter
// A frame is acted on at the fifth clock after select rises
// Serial clock high and low each need three core clocks
// Select high needs six core clocks between frames
// Load and clear pins should stay still while select is low
// Reset release reaches the logic two clocks late
// Code registers take the reset code for six more clocks
// Clear pin wins over every command and the load pin
// Read-back words replace the FIFO at the select rise
`timescale 1ns/10ps
`default_nettype none
`include "dsl_consts.vh"

module dsl_spi_load (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        chip_select_n,
  input  wire        serial_clk,
  input  wire        serial_in,
  output reg         serial_out,
  output reg         serial_out_oe,
  input  wire        load_strobe_n,
  input  wire        clear_n,
  input  wire        midscale_select_pin,
  output reg  [15:0] output_code_reg,
  output reg  [15:0] preload_reg,
  output reg         write_mode_bit,
  output reg         amp_power_down,
  output reg         out_hiz,
  output reg         out_pulldown,
  output reg         frame_abort
);

  // Reset release through two flip-flops
  reg        rst_meta;
  reg        rst_n;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Pin synchronisers
  wire [`DSL_SYNC_WIDTH-1:0] pins_sync;
  dsl_pin_sync #(
    .WIDTH (`DSL_SYNC_WIDTH),
    .INIT  (`DSL_SYNC_INIT)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   ({midscale_select_pin, clear_n, load_strobe_n,
                serial_in, serial_clk, chip_select_n}),
    .pin_out  (pins_sync)
  );

  // Synchronised pin levels
  wire cs_n_s   = pins_sync[0];
  wire sclk_s   = pins_sync[1];
  wire sdi_s    = pins_sync[2];
  wire load_n_s = pins_sync[3];
  wire clr_n_s  = pins_sync[4];
  wire mid_s    = pins_sync[5];

  // Edge detection state
  reg        cs_n_prev;
  reg        sclk_prev;
  wire       cs_fall   = cs_n_prev & ~cs_n_s;
  wire       cs_rise   = ~cs_n_prev & cs_n_s;
  // Clock strobes count only while select is low
  wire       sclk_rise = ~cs_n_s & ~sclk_prev & sclk_s;
  wire       sclk_fall = ~cs_n_s & sclk_prev & ~sclk_s;

  // Frame length and settle state
  reg [`DSL_WORD_BITS-1:0]     shift_reg;
  reg [`DSL_EDGE_CNT_BITS-1:0] edge_cnt;
  reg [2:0]                    settle_cnt;
  reg                          init_done;

  // Decoded fields of the last 24 bits
  // command byte then data
  wire [`DSL_CMD_BITS-1:0]  cmd_byte  = shift_reg[`DSL_WORD_BITS-1:`DSL_DATA_BITS];
  wire [`DSL_DATA_BITS-1:0] data_word = shift_reg[`DSL_DATA_BITS-1:0];
  wire       word_ok   = (edge_cnt == `DSL_WORD_BITS);
  wire       chan_zero = (cmd_byte & ~`DSL_CHAN_MASK) == `DSL_CMD_NOP;
  wire [7:0] cmd_op    = cmd_byte & `DSL_CHAN_MASK;
  wire       chan_sel  = data_word[`DSL_CHAN_BIT];
  wire [15:0] reset_code = mid_s ? `DSL_CODE_MID : `DSL_CODE_ZERO;
  wire [15:0] setup_word = {13'h0000, write_mode_bit, out_pulldown, out_hiz};

  // Decode strobe for a complete frame
  // decode on select rise
  wire       exec      = cs_rise & word_ok & init_done;
  // Config commands need the exact byte
  wire       is_clear  = exec & (cmd_byte == `DSL_CMD_CLEAR);
  wire       is_load   = exec & (cmd_byte == `DSL_CMD_LOAD);
  wire       is_wmode  = exec & (cmd_byte == `DSL_CMD_WMODE);
  wire       is_pdown  = exec & (cmd_byte == `DSL_CMD_PDOWN);
  wire       is_write  = exec & chan_zero & (cmd_op == `DSL_CMD_WRITE);
  wire       is_write_update_cmd   = exec & chan_zero & (cmd_op == `DSL_CMD_WR_UPDATE);
  wire       is_wrall  = exec & chan_zero & (cmd_op == `DSL_CMD_WR_ALL);
  wire       is_rdpre  = exec & chan_zero & (cmd_op == `DSL_CMD_RD_PRE);
  wire       is_rdout  = exec & chan_zero & (cmd_op == `DSL_CMD_RD_OUT);
  wire       is_rdset  = exec & chan_zero & (cmd_op == `DSL_CMD_RD_SETUP);

  // Edge history for select and clock
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_prev <= 1'b1;
      sclk_prev <= 1'b0;
    end else begin
      cs_n_prev <= cs_n_s;
      sclk_prev <= sclk_s;
    end
  end

  // Rising edge counter, saturates; only judges frame length
  // no bit count for decode
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt <= {`DSL_EDGE_CNT_BITS{1'b0}};
    end else if (cs_fall) begin
      edge_cnt <= {`DSL_EDGE_CNT_BITS{1'b0}};
    end else if (sclk_rise && edge_cnt != `DSL_WORD_BITS) begin
      edge_cnt <= edge_cnt + 1'b1;
    end
  end

  // Shift FIFO and read-back load
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= {`DSL_WORD_BITS{1'b0}};
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[`DSL_WORD_BITS-2:0], sdi_s};
    end else if (is_rdpre) begin
      shift_reg <= {cmd_byte, preload_reg};
    end else if (is_rdout) begin
      shift_reg <= {cmd_byte, output_code_reg};
    end else if (is_rdset) begin
      shift_reg <= {cmd_byte, setup_word};
    end
  end

  // Serial output drive and release
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= ~cs_n_s;
      if (cs_fall) begin
        serial_out <= shift_reg[`DSL_WORD_BITS-1];
      end else if (sclk_fall) begin
        // prior bits pass out after 24 cycles
        serial_out <= shift_reg[`DSL_WORD_BITS-1];
      end
    end
  end

  // Abort indication for a short frame
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_abort <= 1'b0;
    end else begin
      frame_abort <= cs_rise & ~word_ok & init_done;
    end
  end

  // Settle wait while loading the power-up code
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt <= 3'h0;
      init_done  <= 1'b0;
    end else if (!init_done) begin
      settle_cnt <= settle_cnt + 3'h1;
      // Midscale level is filtered before the last load
      if (settle_cnt == `DSL_SETTLE_CYCLES) begin
        init_done <= 1'b1;
      end
    end
  end

  // Mode and power-down settings
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_mode_bit <= 1'b0;
      amp_power_down <= 1'b0;
      out_hiz        <= 1'b0;
      out_pulldown   <= 1'b0;
    end else if (!clr_n_s || is_clear) begin
      write_mode_bit <= 1'b0;
      amp_power_down <= 1'b0;
      out_hiz        <= 1'b0;
      out_pulldown   <= 1'b0;
    end else if (is_wmode && chan_sel) begin
      write_mode_bit <= data_word[`DSL_PD_HIZ_BIT];
    end else if (is_pdown && chan_sel) begin
      out_hiz        <= data_word[`DSL_PD_HIZ_BIT];
      out_pulldown   <= data_word[`DSL_PD_10K_BIT] & ~data_word[`DSL_PD_HIZ_BIT];
      amp_power_down <= data_word[`DSL_PD_HIZ_BIT] | data_word[`DSL_PD_10K_BIT];
    end
  end

  // Preload register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      preload_reg <= `DSL_CODE_ZERO;
    end else if (!init_done || !clr_n_s || is_clear) begin
      preload_reg <= reset_code;
    end else if (is_write || is_write_update_cmd || is_wrall) begin
      preload_reg <= data_word;
    end
  end

  // Next output code; reset code, then writes, then loads
  reg [15:0] next_output_code;
  always @* begin
    next_output_code = output_code_reg;
    if (!init_done || !clr_n_s || is_clear) begin
      next_output_code = reset_code;
    end else if (is_write_update_cmd || is_wrall) begin
      next_output_code = data_word;
    end else if (is_write && write_mode_bit) begin
      next_output_code = data_word;
    end else if (is_write && !load_n_s) begin
      next_output_code = data_word;
    end else if (is_load && chan_sel) begin
      next_output_code = preload_reg;
    end else if (!load_n_s) begin
      next_output_code = preload_reg;
    end
  end

  // Output code register
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      output_code_reg <= `DSL_CODE_ZERO;
    end else begin
      output_code_reg <= next_output_code;
    end
  end

endmodule

`default_nettype wire

// ### rtl/dsl_consts.vh
// Constants for the serial load control of the 16-bit output converter
`ifndef DSL_CONSTS_VH
`define DSL_CONSTS_VH

// Shift register and word layout
`define DSL_WORD_BITS      24
`define DSL_CMD_BITS       8
`define DSL_DATA_BITS      16
`define DSL_EDGE_CNT_BITS  5

// Command bytes, channel field in bits 2:0
`define DSL_CMD_NOP        8'h00
`define DSL_CMD_CLEAR      8'h01
`define DSL_CMD_LOAD       8'h18
`define DSL_CMD_WMODE      8'h28
`define DSL_CMD_PDOWN      8'h38
`define DSL_CMD_WRITE      8'h40
`define DSL_CMD_WR_UPDATE  8'h50
`define DSL_CMD_WR_ALL     8'h60
`define DSL_CMD_RD_PRE     8'h90
`define DSL_CMD_RD_OUT     8'hA0
`define DSL_CMD_RD_SETUP   8'hB0
`define DSL_CHAN_MASK      8'hF8
`define DSL_CHAN_BIT       0

// Power-down field positions in the data word
`define DSL_PD_HIZ_BIT     8
`define DSL_PD_10K_BIT     9

// Setup register field positions
`define DSL_CFG_WMODE_BIT  2
`define DSL_CFG_10K_BIT    1
`define DSL_CFG_HIZ_BIT    0

// Reset values of the data registers
`define DSL_CODE_ZERO      16'h0000
`define DSL_CODE_MID       16'h8000

// Cycles to let the pin synchronisers settle after reset
`define DSL_SETTLE_CYCLES  3'h5

// Synchroniser idle levels: midscale, clear_n, load_n, sdi, sclk, cs_n
`define DSL_SYNC_WIDTH     6
`define DSL_SYNC_INIT      6'h1D

`endif

// ### rtl/dsl_pin_sync.v
// Three-stage pin synchroniser with second/third stage agreement filter
`timescale 1ns/10ps
`default_nettype none

module dsl_pin_sync #(
  parameter             WIDTH = 6,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'b0}}
) (
  input  wire             core_clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] pin_out
);

  genvar i;

  // One synchroniser and filter per pin
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg stage1;
      reg stage2;
      reg stage3;
      reg level;

      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1 <= INIT[i];
          stage2 <= INIT[i];
          stage3 <= INIT[i];
          level  <= INIT[i];
        end else begin
          stage1 <= pin_in[i];
          stage2 <= stage1;
          stage3 <= stage2;
          // Change accepted once two later stages agree
          if (stage2 == stage3) begin
            level <= stage3;
          end
        end
      end

      assign pin_out[i] = level;
    end
  endgenerate

endmodule

`default_nettype wire

// ### verification/dsl_monitor.sv
// Checker of the serial load control behaviour at its ports
`timescale 1ns/10ps
`default_nettype none
module dsl_monitor (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        chip_select_n,
  input wire logic        load_strobe_n,
  input wire logic        clear_n,
  input wire logic        midscale_select_pin,
  input wire logic        serial_out_oe,
  input wire logic [15:0] output_code_reg,
  input wire logic [15:0] preload_reg,
  input wire logic        write_mode_bit,
  input wire logic        amp_power_down,
  input wire logic        out_hiz,
  input wire logic        out_pulldown,
  input wire logic        frame_abort
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_oe_off;
    $rose(chip_select_n) |-> ##[1:8] !serial_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output not released");
  property p_oe_on;
    $fell(chip_select_n) |-> ##[1:8] serial_out_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("output not driven");
  property p_pre_hold;
    $changed(preload_reg) |-> chip_select_n || !clear_n;
  endproperty
  a_pre_hold: assert property (p_pre_hold) else $error("preload changed in frame");
  property p_out_hold;
    $changed(output_code_reg) |-> chip_select_n || !clear_n;
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("code changed in frame");
  property p_load_pin;
    (!load_strobe_n && clear_n && $stable(preload_reg))[*8] |-> output_code_reg == preload_reg;
  endproperty
  a_load_pin: assert property (p_load_pin) else $error("load pin not copying");
  property p_clear;
    (!clear_n)[*8] |-> preload_reg == {midscale_select_pin, 15'h0000}
      && output_code_reg == preload_reg && !write_mode_bit && !amp_power_down;
  endproperty
  a_clear: assert property (p_clear) else $error("clear pin not honoured");
  property p_abort_one;
    frame_abort |=> !frame_abort;
  endproperty
  a_abort_one: assert property (p_abort_one) else $error("abort pulse too long");
  property p_abort_keep;
    frame_abort |-> $stable(preload_reg) && $stable(output_code_reg) && $stable(write_mode_bit);
  endproperty
  a_abort_keep: assert property (p_abort_keep) else $error("abort changed state");
  property p_pd;
    out_hiz || out_pulldown |-> amp_power_down && !(out_hiz && out_pulldown);
  endproperty
  a_pd: assert property (p_pd) else $error("bad power-down state");
endmodule
bind dsl_spi_load dsl_monitor dsl_monitor_i (
  .core_clk            (core_clk),
  .reset_n             (reset_n),
  .chip_select_n       (chip_select_n),
  .load_strobe_n       (load_strobe_n),
  .clear_n             (clear_n),
  .midscale_select_pin (midscale_select_pin),
  .serial_out_oe       (serial_out_oe),
  .output_code_reg     (output_code_reg),
  .preload_reg         (preload_reg),
  .write_mode_bit      (write_mode_bit),
  .amp_power_down      (amp_power_down),
  .out_hiz             (out_hiz),
  .out_pulldown        (out_pulldown),
  .frame_abort         (frame_abort)
);
`default_nettype wire

// ### verification/dsl_mst.sv
// Serial master model that frames words toward the converter
`timescale 1ns/10ps
`default_nettype none
module dsl_mst (
  input  wire logic core_clk,
  input  wire logic sdo,
  output var logic  chip_select_n,
  output var logic  serial_clk,
  output var logic  serial_in
);
  // Idle link, clock standing low
  initial begin
    chip_select_n = 1'b1;
    serial_clk = 1'b0;
    serial_in = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // Sends low n bits of w MSB first, returns the bits seen on sdo
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] got);
    got = 48'h000000000000;
    hp(1);
    chip_select_n = 1'b0;
    hp(8);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      hp(4);
      serial_clk = 1'b1;
      hp(4);
      got = {got[46:0], sdo};
      serial_clk = 1'b0;
    end
    hp(4);
    chip_select_n = 1'b1;
    serial_in = ~serial_in;
    hp(14);
  endtask
endmodule
`default_nettype wire

// ### verification/test_dsl_spi_load.sv
// Self-checking bench of the serial load control
`timescale 1ns/10ps
`default_nettype none
module test_dsl_spi_load;
  logic        core_clk;
  logic        reset_n;
  logic        chip_select_n;
  logic        serial_clk;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_oe;
  logic        load_strobe_n;
  logic        clear_n;
  logic        midscale_select_pin;
  logic [15:0] output_code_reg;
  logic [15:0] preload_reg;
  logic        write_mode_bit;
  logic        amp_power_down;
  logic        out_hiz;
  logic        out_pulldown;
  logic        frame_abort;
  logic [47:0] got;
  int          fails;
  int          check_count;
  int          abort_seen;
  wire         sdo;
  assign sdo = serial_out_oe ? serial_out : 1'bz;
  dsl_spi_load dsl_spi_load_i (
    .core_clk            (core_clk),
    .reset_n             (reset_n),
    .chip_select_n       (chip_select_n),
    .serial_clk          (serial_clk),
    .serial_in           (serial_in),
    .serial_out          (serial_out),
    .serial_out_oe       (serial_out_oe),
    .load_strobe_n       (load_strobe_n),
    .clear_n             (clear_n),
    .midscale_select_pin (midscale_select_pin),
    .output_code_reg     (output_code_reg),
    .preload_reg         (preload_reg),
    .write_mode_bit      (write_mode_bit),
    .amp_power_down      (amp_power_down),
    .out_hiz             (out_hiz),
    .out_pulldown        (out_pulldown),
    .frame_abort         (frame_abort)
  );
  dsl_mst dsl_mst_i (
    .core_clk      (core_clk),
    .sdo           (sdo),
    .chip_select_n (chip_select_n),
    .serial_clk    (serial_clk),
    .serial_in     (serial_in)
  );
  // Abort pulses counted between clock edges
  always @(negedge core_clk) begin
    if (frame_abort === 1'b1)
      abort_seen++;
  end
  // Clock of 20 ns
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input string n, input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // every command except clear (01) keeps channel field zero
  task automatic tx(input logic [23:0] w);
    dsl_mst_i.xfer({24'h000000, w}, 24, got);
  endtask
  task automatic regs(input logic [15:0] p, input logic [15:0] o);
    chk("preload", preload_reg, p);
    chk("code", output_code_reg, o);
  endtask
  task automatic t_power;
    regs(16'h8000, 16'h8000);
    chk("mode", write_mode_bit, 24'h000000);
    chk("oe", serial_out_oe, 24'h000000);
  endtask
  task automatic t_block;
    tx(24'h401234);
    regs(16'h1234, 16'h8000);
    tx(24'h180000);
    regs(16'h1234, 16'h8000);
    tx(24'h180001);
    regs(16'h1234, 16'h1234);
    tx(24'h50A5A5);
    regs(16'hA5A5, 16'hA5A5);
    tx(24'h605A5A);
    regs(16'h5A5A, 16'h5A5A);
  endtask
  task automatic t_mode;
    tx(24'h280101);
    chk("mode", write_mode_bit, 24'h000001);
    tx(24'h405555);
    regs(16'h5555, 16'h5555);
    tx(24'h280001);
    dsl_mst_i.xfer({24'h000000, 24'h407777}, 23, got);
    regs(16'h5555, 16'h5555);
    chk("abort", abort_seen, 24'h000001);
  endtask
  task automatic t_read;
    logic [23:0] e [3];
    e = '{24'h901111, 24'hA05555, 24'hB00000};
    tx(24'h401111);
    for (int i = 0; i < 3; i++) begin
      tx({e[i][23:16], 16'h0000});
      tx(24'h000000);
      chk("read", got[23:0], e[i]);
    end
  endtask
  task automatic t_chain;
    dsl_mst_i.xfer({24'h0F0F0F, 24'h402222}, 48, got);
    chk("old fifo", got[47:24], 24'h000000);
    chk("passed", got[23:0], 24'h0F0F0F);
    regs(16'h2222, 16'h5555);
  endtask
  task automatic t_pdown;
    logic [15:0] d [4];
    logic [2:0]  e [4];
    d = '{16'h0101, 16'h0201, 16'h0301, 16'h0001};
    e = '{3'h6, 3'h5, 3'h6, 3'h0};
    for (int i = 0; i < 4; i++) begin
      tx({8'h38, d[i]});
      chk("pdown", {amp_power_down, out_hiz, out_pulldown}, e[i]);
    end
  endtask
  task automatic t_pins;
    load_strobe_n = 1'b0;
    repeat (10) @(negedge core_clk);
    regs(16'h2222, 16'h2222);
    tx(24'h404444);
    regs(16'h4444, 16'h4444);
    load_strobe_n = 1'b1;
    clear_n = 1'b0;
    repeat (10) @(negedge core_clk);
    regs(16'h8000, 16'h8000);
    clear_n = 1'b1;
    tx(24'h280101);
    tx(24'h400001);
    tx(24'h010000);
    regs(16'h8000, 16'h8000);
    chk("mode", write_mode_bit, 24'h000000);
    midscale_select_pin = 1'b0;
    clear_n = 1'b0;
    repeat (10) @(negedge core_clk);
    regs(16'h0000, 16'h0000);
    clear_n = 1'b1;
    midscale_select_pin = 1'b1;
  endtask
  task automatic test_done;
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Watchdog against a hung frame
  initial begin
    #500us;
    fails++;
    test_done;
  end
  // Reset, then the scenarios
  initial begin
    fails = 0;
    check_count = 0;
    abort_seen = 0;
    reset_n = 1'b0;
    load_strobe_n = 1'b1;
    clear_n = 1'b1;
    midscale_select_pin = 1'b1;
    repeat (2) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (12) @(negedge core_clk);
    t_power;
    t_block;
    t_mode;
    t_read;
    t_chain;
    t_pdown;
    t_pins;
    test_done;
  end
endmodule
`default_nettype wire
